//--- design/dfr_current_readback.sv
`timescale 1ns/1ns
// Overview of operation
// RULE1 - A request holds the read/write flag in bit 31 and the message code in bits 30:27, code 0101 meaning the peak readback.
// RULE2 - One channel selection, taken from bits 26:24 of either readback request, serves both readbacks.
// RULE3 - The peak answer has bit 31 zero, echoes code and channel, bit 23 zero, valid in 22, max in 21:11 and min in 10:0 as top 11 bits.
// RULE4 - The peak valid flag sets on new data, clears on a peak read or a channel change, and resets to zero.
// RULE5 - The max is the largest per-period sum of the previous dither cycle and reads zero until a cycle completes.
// RULE6 - The min is the smallest per-period sum of the previous dither cycle and reads 2047 until a cycle completes.
// RULE7 - Fresh peak data arrives within two dither cycles after a channel change and within one otherwise.
// RULE8 - Code 0110 selects the average readback for the channel in bits 26:24, other request bits unused.
// RULE9 - The average answer echoes code and channel, zeros in 23:21, valid in 20 and the 20-bit dither sum in 19:0, reset zero.
// RULE10 - The average valid flag sets on new data, clears on an average read or a channel change, and resets to zero.
// RULE11 - Fresh average data arrives within two dither cycles after a channel change and within one otherwise.
// RULE12 - At 512 samples per period in direct mode the host checks for overflow and rescales.
// RULE13 - A dither cycle lasts four times the step count in pwm periods, and zero steps disables it.
// RULE14 - Max, min and average holding values load together at each dither cycle boundary.
module dfr_current_readback
    import dfr_pkg::*;
#(
    parameter int SUM_W = SUM_W_DEF,
    parameter int CHANNELS = NUM_CHANNEL_SELECT
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic linkClk,
    input wire logic reqStrobe,
    input wire logic [31:0] reqWord,
    input wire logic pwmEnd,
    input wire logic [CHANNELS-1:0][SUM_W-1:0] periodSum,
    input wire logic [CHANNELS-1:0][STEP_W-1:0] ditherSteps,
    output logic [31:0] respWord_q,
    output logic respValid_q,
    output logic respHit_q,
    output logic reqBusy_q
);

    function automatic logic isReadback(input logic [CODE_W-1:0] code);
        return (code == CODE_PEAK) || (code == CODE_AVG);
    endfunction

    // reset asserts at once but lets go of each domain only on its own
    // clock, two flops in, so no flop sees the release near its edge
    logic coreRstMeta_q;
    logic coreRstSync_q;
    logic coreRst_b;
    logic linkRstMeta_q;
    logic linkRstSync_q;
    logic linkRst_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            coreRstMeta_q <= 1'b0;
            coreRstSync_q <= 1'b0;
        end else begin
            coreRstMeta_q <= 1'b1;
            coreRstSync_q <= coreRstMeta_q;
        end
    end

    always_ff @(posedge linkClk or negedge rst_b) begin
        if (!rst_b) begin
            linkRstMeta_q <= 1'b0;
            linkRstSync_q <= 1'b0;
        end else begin
            linkRstMeta_q <= 1'b1;
            linkRstSync_q <= linkRstMeta_q;
        end
    end

    assign coreRst_b = coreRstSync_q;
    assign linkRst_b = linkRstSync_q;

    // ------------------------------------------------------------------
    // link side, on linkClk
    // ------------------------------------------------------------------

    logic [31:0] reqHold_q;
    logic reqTog_q;
    logic ackMeta_q;
    logic ackSync_q;
    logic ackSeen_q;
    logic ackEdge;
    logic reqTake;

    // core side signals read by the link side
    logic ackTog_q;
    logic [31:0] respHold_q;
    logic hitHold_q;

    // a request during a pending one is dropped; reqBusy_q tells the framer
    assign reqTake = reqStrobe && !reqBusy_q;
    assign ackEdge = ackSync_q ^ ackSeen_q;

    // word stays frozen until the core answers, so it may cross unsynced
    always_ff @(posedge linkClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            reqHold_q <= '0;
        end else if (reqTake) begin
            reqHold_q <= reqWord;
        end
    end

    always_ff @(posedge linkClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            reqTog_q <= 1'b0;
        end else if (reqTake) begin
            reqTog_q <= ~reqTog_q;
        end
    end

    always_ff @(posedge linkClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            reqBusy_q <= 1'b0;
        end else if (reqTake) begin
            reqBusy_q <= 1'b1;
        end else if (ackEdge) begin
            reqBusy_q <= 1'b0;
        end
    end

    always_ff @(posedge linkClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            ackMeta_q <= 1'b0;
            ackSync_q <= 1'b0;
            ackSeen_q <= 1'b0;
        end else begin
            ackMeta_q <= ackTog_q;
            ackSync_q <= ackMeta_q;
            ackSeen_q <= ackSync_q;
        end
    end

    // answer word is held by the core for as long as the ack toggle lags
    always_ff @(posedge linkClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            respWord_q <= '0;
        end else if (ackEdge) begin
            respWord_q <= respHold_q;
        end
    end

    always_ff @(posedge linkClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            respHit_q <= 1'b0;
        end else if (ackEdge) begin
            respHit_q <= hitHold_q;
        end
    end

    always_ff @(posedge linkClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            respValid_q <= 1'b0;
        end else begin
            respValid_q <= ackEdge;
        end
    end

    // ------------------------------------------------------------------
    // core side, on clk
    // ------------------------------------------------------------------

    logic reqMeta_q;
    logic reqSync_q;
    logic reqSeen_q;
    logic reqEdge;
    dfr_req_t req;
    logic hit;
    logic peakRead;
    logic avgRead;
    logic chanChange;

    logic [CHANNEL_SELECT_W-1:0] channelSelect_q;
    logic peakValid_q;
    logic avgValid_q;
    logic [REPORT_W-1:0] maxHold_q;
    logic [REPORT_W-1:0] minHold_q;
    logic [AVG_W-1:0] avgHold_q;

    logic cycleDone;
    dfr_window_t windowResult;
    logic loadHold;

    dfr_peak_resp_t peakResp;
    dfr_avg_resp_t avgResp;

    always_ff @(posedge clk or negedge coreRst_b) begin
        if (!coreRst_b) begin
            reqMeta_q <= 1'b0;
            reqSync_q <= 1'b0;
            reqSeen_q <= 1'b0;
        end else begin
            reqMeta_q <= reqTog_q;
            reqSync_q <= reqMeta_q;
            reqSeen_q <= reqSync_q;
        end
    end

    assign reqEdge = reqSync_q ^ reqSeen_q;
    assign req = dfr_req_t'(reqHold_q); // RULE1

    // a write to either code is answered exactly like a read
    assign hit = reqEdge && isReadback(req.messageCode); // RULE1 RULE8
    assign peakRead = hit && (req.messageCode == CODE_PEAK); // RULE1
    assign avgRead = hit && (req.messageCode == CODE_AVG); // RULE8
    assign chanChange = hit && (req.channelSelect != channelSelect_q); // RULE2

    // either readback moves the one shared selection
    always_ff @(posedge clk or negedge coreRst_b) begin
        if (!coreRst_b) begin
            channelSelect_q <= CHANNEL_SELECT_RESET;
        end else if (hit) begin
            channelSelect_q <= req.channelSelect; // RULE2
        end
    end

    // and-or pick of the selected channel's inputs; every channel
    // gets the same gating, so the select never sees a wide index mux
    logic [CHANNELS-1:0] chanHit;
    logic [CHANNELS-1:0][SUM_W-1:0] sumPick;
    logic [CHANNELS-1:0][STEP_W-1:0] stepsPick;
    logic [SUM_W-1:0] selSum;
    logic [STEP_W-1:0] selSteps;

    for (genvar c = 0; c < CHANNELS; c++) begin : g_pick
        assign chanHit[c] = (channelSelect_q == CHANNEL_SELECT_W'(c));
        assign sumPick[c] = chanHit[c] ? periodSum[c] : '0;
        assign stepsPick[c] = chanHit[c] ? ditherSteps[c] : '0;
    end

    always_comb begin
        selSum = '0;
        selSteps = '0;
        for (int c = 0; c < CHANNELS; c++) begin
            selSum = selSum | sumPick[c];
            selSteps = selSteps | stepsPick[c];
        end
    end

    // a channel change restarts the window, so the first full cycle of
    // the new channel completes one full cycle of the new count after the change
    dfr_dither_window #(
        .SUM_W(SUM_W)
    ) window (
        .clk(clk),
        .rst_b(coreRst_b),
        .restart(chanChange), // RULE7 RULE11
        .pwmEnd(pwmEnd),
        .periodSum(selSum),
        .steps(selSteps),
        .cycleDone(cycleDone),
        .result(windowResult)
    );

    // a result still in flight from the old channel is thrown away
    assign loadHold = cycleDone && !chanChange;

    always_ff @(posedge clk or negedge coreRst_b) begin
        if (!coreRst_b) begin
            maxHold_q <= PEAK_MAX_RESET; // RULE5
            minHold_q <= PEAK_MIN_RESET; // RULE6
            avgHold_q <= AVG_RESET; // RULE9
        end else if (loadHold) begin
            maxHold_q <= windowResult.maxTop; // RULE14 RULE5
            minHold_q <= windowResult.minTop; // RULE14 RULE6
            avgHold_q <= windowResult.avgSum; // RULE14
        end
    end

    // set beats clear, so a boundary in the read cycle is not lost
    always_ff @(posedge clk or negedge coreRst_b) begin
        if (!coreRst_b) begin
            peakValid_q <= 1'b0;
        end else if (loadHold) begin
            peakValid_q <= 1'b1; // RULE4
        end else if (peakRead || chanChange) begin
            peakValid_q <= 1'b0; // RULE4
        end
    end

    always_ff @(posedge clk or negedge coreRst_b) begin
        if (!coreRst_b) begin
            avgValid_q <= 1'b0;
        end else if (loadHold) begin
            avgValid_q <= 1'b1; // RULE10
        end else if (avgRead || chanChange) begin
            avgValid_q <= 1'b0; // RULE10
        end
    end

    // flags shown are those before this read; a change hides stale data
    always_comb begin
        peakResp = '0;
        peakResp.messageCode = CODE_PEAK; // RULE3
        peakResp.channelSelect = req.channelSelect; // RULE3
        peakResp.valid = peakValid_q && !chanChange; // RULE3 RULE4
        peakResp.maxTop = maxHold_q; // RULE3
        peakResp.minTop = minHold_q; // RULE3
    end

    always_comb begin
        avgResp = '0;
        avgResp.messageCode = CODE_AVG; // RULE9
        avgResp.channelSelect = req.channelSelect; // RULE9
        avgResp.valid = avgValid_q && !chanChange; // RULE9 RULE10
        avgResp.avgSum = avgHold_q; // RULE9
    end

    // every request is acknowledged, even an unknown code, so the
    // link side never hangs; respHit_q tells the framer which it was
    always_ff @(posedge clk or negedge coreRst_b) begin
        if (!coreRst_b) begin
            hitHold_q <= 1'b0;
        end else if (reqEdge) begin
            hitHold_q <= hit;
        end
    end

    always_ff @(posedge clk or negedge coreRst_b) begin
        if (!coreRst_b) begin
            respHold_q <= '0;
        end else if (reqEdge) begin
            case (req.messageCode)
                CODE_PEAK: begin
                    respHold_q <= peakResp;
                end
                CODE_AVG: begin
                    respHold_q <= avgResp;
                end
                default: begin
                    respHold_q <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge coreRst_b) begin
        if (!coreRst_b) begin
            ackTog_q <= 1'b0;
        end else if (reqEdge) begin
            ackTog_q <= ~ackTog_q;
        end
    end

endmodule

//--- design/dfr_pkg.sv
package dfr_pkg;

    localparam int NUM_CHANNEL_SELECT = 8;
    localparam int CHANNEL_SELECT_W = 3;
    localparam int CODE_W = 4;
    localparam int STEP_W = 5;
    localparam int REPORT_W = 11;
    localparam int AVG_W = 20;
    localparam int SUM_W_DEF = 13;
    localparam int QUARTERS_LOG2 = 2;

    localparam logic READ_FLAG = 1'b0;
    localparam logic [CODE_W-1:0] CODE_PEAK = 4'h5;
    localparam logic [CODE_W-1:0] CODE_AVG = 4'h6;
    localparam logic [CHANNEL_SELECT_W-1:0] CHANNEL_SELECT_RESET = 3'h0;
    localparam logic [REPORT_W-1:0] PEAK_MAX_RESET = 11'h000;
    localparam logic [REPORT_W-1:0] PEAK_MIN_RESET = 11'h7ff;
    localparam logic [AVG_W-1:0] AVG_RESET = 20'h00000;

    typedef struct packed {
        logic readWrite;
        logic [CODE_W-1:0] messageCode;
        logic [CHANNEL_SELECT_W-1:0] channelSelect;
        logic [23:0] unused;
    } dfr_req_t;

    typedef struct packed {
        logic zeroTop;
        logic [CODE_W-1:0] messageCode;
        logic [CHANNEL_SELECT_W-1:0] channelSelect;
        logic zeroMid;
        logic valid;
        logic [REPORT_W-1:0] maxTop;
        logic [REPORT_W-1:0] minTop;
    } dfr_peak_resp_t;

    typedef struct packed {
        logic zeroTop;
        logic [CODE_W-1:0] messageCode;
        logic [CHANNEL_SELECT_W-1:0] channelSelect;
        logic [2:0] zeroMid;
        logic valid;
        logic [AVG_W-1:0] avgSum;
    } dfr_avg_resp_t;

    typedef struct packed {
        logic [REPORT_W-1:0] maxTop;
        logic [REPORT_W-1:0] minTop;
        logic [AVG_W-1:0] avgSum;
    } dfr_window_t;

endpackage

//--- design/dfr_dither_window.sv
`timescale 1ns/1ns
module dfr_dither_window
    import dfr_pkg::*;
#(
    parameter int SUM_W = SUM_W_DEF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic restart,
    input wire logic pwmEnd,
    input wire logic [SUM_W-1:0] periodSum,
    input wire logic [STEP_W-1:0] steps,
    output logic cycleDone,
    output dfr_window_t result
);
    localparam int CNT_W = STEP_W + QUARTERS_LOG2;

    logic [CNT_W-1:0] periodCnt_q;
    logic [CNT_W-1:0] periodsPerCycle;
    logic [REPORT_W-1:0] runMax_q;
    logic [REPORT_W-1:0] runMin_q;
    logic [AVG_W-1:0] runSum_q;
    logic open_q;
    logic ditherOn;
    logic lastPeriod;
    logic [REPORT_W-1:0] topBits;
    logic [REPORT_W-1:0] newMax;
    logic [REPORT_W-1:0] newMin;
    logic [AVG_W-1:0] newSum;

    // one dither cycle is four quarter waveforms of steps pwm periods
    assign periodsPerCycle = {steps, 2'b00}; // RULE13
    assign ditherOn = (steps != '0); // RULE13
    assign lastPeriod = ditherOn && (periodCnt_q >= periodsPerCycle - 1'b1);
    assign topBits = periodSum[SUM_W-1 -: REPORT_W];
    assign newMax = (open_q || topBits > runMax_q) ? topBits : runMax_q;
    assign newMin = (open_q || topBits < runMin_q) ? topBits : runMin_q;
    // wraps silently; the host watches for overflow at large sample counts
    assign newSum = open_q ? AVG_W'(periodSum)
                           : runSum_q + AVG_W'(periodSum);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            periodCnt_q <= '0;
        end else if (restart || !ditherOn) begin
            periodCnt_q <= '0;
        end else if (pwmEnd) begin
            periodCnt_q <= lastPeriod ? '0 : periodCnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            open_q <= 1'b1;
            runMax_q <= PEAK_MAX_RESET;
            runMin_q <= PEAK_MIN_RESET;
            runSum_q <= AVG_RESET;
        end else if (restart || !ditherOn) begin
            open_q <= 1'b1;
        end else if (pwmEnd) begin
            open_q <= lastPeriod;
            runMax_q <= newMax;
            runMin_q <= newMin;
            runSum_q <= newSum;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cycleDone <= 1'b0;
            result <= '{PEAK_MAX_RESET, PEAK_MIN_RESET, AVG_RESET};
        end else begin
            cycleDone <= pwmEnd && lastPeriod && !restart;
            if (pwmEnd && lastPeriod && !restart) begin
                result <= '{newMax, newMin, newSum};
            end
        end
    end

endmodule

//--- test/dfr_current_readback_chk.sv
`timescale 1ns/1ns
module dfr_current_readback_chk
    import dfr_pkg::*;
(
    input wire logic linkClk,
    input wire logic rst_b,
    input wire logic reqStrobe,
    input wire logic [31:0] reqWord,
    input wire logic [31:0] respWord_q,
    input wire logic respValid_q,
    input wire logic respHit_q,
    input wire logic reqBusy_q
);
    logic [2:0] lastChan_q;
    logic take;
    logic [3:0] code;
    assign take = reqStrobe && !reqBusy_q;
    assign code = respWord_q[30:27];
    always_ff @(posedge linkClk or negedge rst_b) begin
        if (!rst_b) begin
            lastChan_q <= CHANNEL_SELECT_RESET;
        end else if (take) begin
            lastChan_q <= reqWord[26:24];
        end
    end
    default clocking @(posedge linkClk); endclocking
    default disable iff (!rst_b);
    take_busy_a: assert property (take |=> reqBusy_q)
        else $error("busy not raised after a taken request");
    answer_time_a: assert property (take |-> ##[2:10] respValid_q)
        else $error("no answer within ten link cycles");
    busy_hold_a: assert property (
        reqBusy_q && !respValid_q |=> reqBusy_q || respValid_q)
        else $error("busy dropped without an answer");
    answer_free_a: assert property (respValid_q |-> !reqBusy_q)
        else $error("busy still high at the answer");
    word_stands_a: assert property (
        !respValid_q |-> $stable(respWord_q))
        else $error("answer word moved without an answer pulse");
    miss_zero_a: assert property (
        respValid_q && !respHit_q |-> respWord_q == 32'h0)
        else $error("unknown code answered with a nonzero word");
    hit_code_a: assert property (respValid_q |->
        respHit_q == (code == CODE_PEAK || code == CODE_AVG))
        else $error("hit flag disagrees with the echoed code");
    peak_frame_a: assert property (
        respValid_q && respHit_q && code == CODE_PEAK
        |-> !respWord_q[31] && !respWord_q[23])
        else $error("peak answer fixed bits wrong");
    avg_frame_a: assert property (
        respValid_q && respHit_q && code == CODE_AVG
        |-> !respWord_q[31] && respWord_q[23:21] == 3'h0)
        else $error("average answer fixed bits wrong");
    echo_channel_select_a: assert property (
        respValid_q && respHit_q |-> respWord_q[26:24] == lastChan_q)
        else $error("answer channel differs from the request");
    cover property (respValid_q && code == CODE_PEAK && respWord_q[22]);
    cover property (respValid_q && code == CODE_AVG && respWord_q[20]);
    cover property (respValid_q && !respHit_q);
endmodule
bind dfr_current_readback dfr_current_readback_chk dfr_current_readback_chk_i (
    .linkClk(linkClk), .rst_b(rst_b), .reqStrobe(reqStrobe),
    .reqWord(reqWord), .respWord_q(respWord_q), .respValid_q(respValid_q),
    .respHit_q(respHit_q), .reqBusy_q(reqBusy_q));

//--- test/dfr_host_model.sv
`timescale 1ns/1ns
module dfr_host_model (
    input wire logic linkClk,
    output logic reqStrobe,
    output logic [31:0] reqWord,
    input wire logic respValid_q,
    input wire logic [31:0] respWord_q,
    input wire logic respHit_q
);
    initial begin
        reqStrobe = 1'b0;
        reqWord = 32'h0;
    end
    // one request outstanding; dup keeps strobe up into the busy cycle
    task automatic xfer(input logic [31:0] w, input logic dup,
                        output logic [31:0] ans, output logic hit,
                        output logic extra);
        int n;
        n = 0;
        extra = 1'b0;
        @(posedge linkClk);
        reqStrobe <= 1'b1;
        reqWord <= w;
        repeat (dup ? 2 : 1) @(posedge linkClk);
        reqStrobe <= 1'b0;
        // released word must not look like a held request
        reqWord <= ~w;
        do begin
            @(posedge linkClk);
            #1;
            n++;
        end while (respValid_q !== 1'b1 && n < 10);
        ans = respWord_q;
        hit = respHit_q;
        // no answer in time: poison both so the compare fails
        if (respValid_q !== 1'b1) begin
            ans = 'x;
            hit = 1'bx;
        end
        if (dup) begin
            repeat (8) begin
                @(posedge linkClk);
                #1;
                extra = extra | (respValid_q !== 1'b0);
            end
        end
    endtask
endmodule

//--- test/dither_current_feedback_readout_tb_top.sv
`timescale 1ns/1ns
module dither_current_feedback_readout_tb_top;
    import dfr_pkg::*;
    logic clk, linkClk, rst_b, pwmEnd, reqStrobe;
    logic respValid_q, respHit_q, reqBusy_q, hit, extra;
    logic [31:0] reqWord, respWord_q, ans;
    logic [NUM_CHANNEL_SELECT-1:0][SUM_W_DEF-1:0] periodSum;
    logic [NUM_CHANNEL_SELECT-1:0][STEP_W-1:0] ditherSteps;
    int num_errors, checks_done, seed, cnt;
    logic [2:0] ch;
    logic [12:0] aMax, aMin;
    logic [19:0] aSum, hAvg;
    logic [10:0] hMax, hMin;
    logic vPeak, vAvg;

    dfr_current_readback #(.SUM_W(SUM_W_DEF), .CHANNELS(NUM_CHANNEL_SELECT))
    dfr_current_readback_i (.clk(clk), .rst_b(rst_b), .linkClk(linkClk),
        .reqStrobe(reqStrobe), .reqWord(reqWord), .pwmEnd(pwmEnd),
        .periodSum(periodSum), .ditherSteps(ditherSteps),
        .respWord_q(respWord_q), .respValid_q(respValid_q),
        .respHit_q(respHit_q), .reqBusy_q(reqBusy_q));
    dfr_host_model dfr_host_model_i (.linkClk(linkClk),
        .reqStrobe(reqStrobe), .reqWord(reqWord),
        .respValid_q(respValid_q), .respWord_q(respWord_q),
        .respHit_q(respHit_q));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        linkClk = 1'b0;
        #3;
        forever #15 linkClk = ~linkClk;
    end

    task automatic test_done();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    function automatic logic [31:0] expectWord(logic [3:0] code,
                                               logic [2:0] rc);
        logic same;
        same = (rc == ch);
        expectWord = 32'h0;
        if (code == CODE_PEAK) begin
            expectWord = {1'b0, code, rc, 1'b0, vPeak && same, hMax, hMin};
        end
        if (code == CODE_AVG) begin
            expectWord = {1'b0, code, rc, 3'h0, vAvg && same, hAvg};
        end
    endfunction

    task automatic check(string nm, logic [31:0] e, logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic period();
        logic [NUM_CHANNEL_SELECT-1:0][SUM_W_DEF-1:0] v;
        logic [12:0] s;
        for (int i = 0; i < NUM_CHANNEL_SELECT; i++) v[i] = 13'($random(seed));
        s = v[ch];
        @(posedge clk);
        periodSum <= v;
        pwmEnd <= 1'b1;
        @(posedge clk);
        pwmEnd <= 1'b0;
        repeat (3) @(posedge clk);
        if (ditherSteps[ch] != 5'h0) begin
            if (cnt == 0 || s > aMax) aMax = s;
            if (cnt == 0 || s < aMin) aMin = s;
            aSum = (cnt == 0) ? 20'(s) : aSum + 20'(s);
            cnt++;
            if (cnt == 4 * ditherSteps[ch]) begin
                hMax = aMax[12:2];
                hMin = aMin[12:2];
                hAvg = aSum;
                vPeak = 1'b1;
                vAvg = 1'b1;
                cnt = 0;
            end
        end
    endtask

    task automatic do_read(logic [3:0] code, logic [2:0] rc, logic dup);
        logic [31:0] w, e;
        logic eh;
        w = $random(seed);
        w[30:27] = code;
        w[26:24] = rc;
        eh = (code == CODE_PEAK || code == CODE_AVG);
        e = expectWord(code, rc);
        if (eh && rc != ch) begin
            ch = rc;
            vPeak = 1'b0;
            vAvg = 1'b0;
            cnt = 0;
        end else if (code == CODE_PEAK) vPeak = 1'b0;
        else if (code == CODE_AVG) vAvg = 1'b0;
        dfr_host_model_i.xfer(w, dup, ans, hit, extra);
        check("answer word", e, ans);
        check("hit flag", {31'h0, eh}, {31'h0, hit});
        check("extra answer", 32'h0, {31'h0, extra});
    endtask

    initial begin
        #600000;
        num_errors++;
        test_done();
    end

    initial begin
        seed = 32'ha69d;
        num_errors = 0;
        checks_done = 0;
        rst_b = 1'b0;
        pwmEnd = 1'b0;
        periodSum = '0;
        {ch, cnt, vPeak, vAvg, hMax, hAvg} = '0;
        hMin = 11'h7ff;
        for (int i = 0; i < NUM_CHANNEL_SELECT; i++)
            ditherSteps[i] = 5'(1 + $unsigned($random(seed)) % 3);
        ditherSteps[1] = 5'h0;
        ditherSteps[7] = 5'h1f;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk);
        do_read(CODE_PEAK, 3'h0, 1'b0);
        do_read(CODE_AVG, 3'h0, 1'b0);
        // longest window: every period counts, both flags set together
        do_read(CODE_PEAK, 3'h7, 1'b0);
        repeat (124) period();
        do_read(CODE_PEAK, 3'h7, 1'b0);
        do_read(CODE_AVG, 3'h7, 1'b1);
        // zero steps: no window ever closes
        do_read(CODE_AVG, 3'h1, 1'b0);
        repeat (20) period();
        do_read(CODE_AVG, 3'h1, 1'b0);
        for (int r = 0; r < 60; r++) begin
            repeat ($unsigned($random(seed)) % 14) period();
            do_read((r % 3 == 2) ? 4'($random(seed)) :
                    ((r % 2 == 1) ? CODE_AVG : CODE_PEAK),
                    ($random(seed) % 4 == 0) ? 3'($random(seed)) : ch,
                    r % 9 == 0);
        end
        test_done();
    end
endmodule
